// >>> inc/fec_pkg.sv
package fec_pkg;
  localparam int CLK_MHZ        = 10;              // System clock rate
  localparam int ADDR_W         = 22;              // Flash address width
  localparam int DATA_W         = 16;              // Flash data width
  // Bus write phase lengths in ns, rounded up to whole cycles
  localparam int T_SETUP_NS     = 100;             // Address set before write strobe falls
  localparam int T_PULSE_NS     = 100;             // Write strobe low time
  localparam int T_HOLD_NS      = 100;             // Hold and recovery after rise
  localparam int T_SETUP_CYC    = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_PULSE_CYC    = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int T_HOLD_CYC     = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  // Abort wait after reset-to-read during block select timeout
  localparam int T_ABORT_US     = 10;
  localparam int T_ABORT_CYC    = T_ABORT_US * CLK_MHZ;
  localparam int CNT_W          = 8;               // Phase counter width
  // Command writes: count per command code
  localparam logic [2:0] N_RESET   = 3'h1;         // Short reset form
  localparam logic [2:0] N_RESET3  = 3'h3;         // Long reset form
  localparam logic [2:0] N_IDENT   = 3'h3;         // Identification entry
  localparam logic [2:0] N_QUERY   = 3'h1;         // Query entry
  localparam logic [2:0] N_ERASE   = 3'h6;         // Chip or block erase
  localparam logic [2:0] N_SUSP    = 3'h1;         // Erase suspend or resume
  // Host command codes on cmd_i
  localparam logic [2:0] C_RESET   = 3'h0;
  localparam logic [2:0] C_RESET3  = 3'h1;
  localparam logic [2:0] C_IDENT   = 3'h2;
  localparam logic [2:0] C_QUERY   = 3'h3;
  localparam logic [2:0] C_CHIP    = 3'h4;
  localparam logic [2:0] C_BLOCK   = 3'h5;         // Also adds a block
  localparam logic [2:0] C_SUSP    = 3'h6;
  localparam logic [2:0] C_RESUME  = 3'h7;
  typedef enum logic [3:0] {
    FEC_IDLE  = 4'h1,
    FEC_SETUP = 4'h2,
    FEC_PULSE = 4'h4,
    FEC_HOLD  = 4'h8
  } fec_phase_t;
endpackage : fec_pkg

// >>> rtl/fec_host.sv
`timescale 1ns/100ps
`default_nettype none
// Host end: turns a command code into a bus write sequence on the flash pins
module fec_host (
  input  wire logic                      clock_i,    // 10 MHz clock
  input  wire logic                      rst_b_i,    // Async reset, low
  input  wire logic                      req_i,      // Command request pulse
  input  wire logic [2:0]                cmd_i,      // Command code
  input  wire logic [fec_pkg::ADDR_W-1:0] blk_addr_i, // Block address for erase
  input  wire logic [fec_pkg::ADDR_W*6-1:0] seq_addr_i, // Table addresses, write 1 low
  input  wire logic [fec_pkg::DATA_W*6-1:0] seq_data_i, // Table data, write 1 low
  output logic                           busy_o,     // Sequence in progress
  output logic                           done_o,     // Sequence end pulse
  output logic                           chip_en_b_o, // Chip enable, low
  output logic                           wr_en_b_o,  // Write enable, low
  output logic                           out_en_b_o, // Output enable, low
  output logic [fec_pkg::ADDR_W-1:0]     addr_o,     // Flash address
  output logic [fec_pkg::DATA_W-1:0]     dq_o,       // Data to flash
  output logic                           dq_oe_o     // High while driving data
);
  import fec_pkg::*;

  // Writes needed per command code
  function automatic logic [2:0] cmd_len(input logic [2:0] c);
    case (c)
      C_RESET:  cmd_len = N_RESET;
      C_RESET3: cmd_len = N_RESET3;
      C_IDENT:  cmd_len = N_IDENT;
      C_QUERY:  cmd_len = N_QUERY;
      C_CHIP:   cmd_len = N_ERASE;
      C_BLOCK:  cmd_len = N_ERASE;
      default:  cmd_len = N_SUSP;
    endcase
  endfunction : cmd_len

  // Address of write i: the sixth block erase write carries the block
  function automatic logic [ADDR_W-1:0] wr_addr(input logic [2:0]          c,
                                                input logic [2:0]          i,
                                                input logic [ADDR_W-1:0]   blk,
                                                input logic [ADDR_W*6-1:0] tab);
    if (c == C_BLOCK && i == 3'h5) begin
      wr_addr = blk;
    end else begin
      wr_addr = tab[i*ADDR_W +: ADDR_W];
    end
  endfunction : wr_addr

  // Whole module state
  typedef struct packed {
    fec_phase_t          phase;    // Bus write phase
    logic [2:0]          cmd;      // Active command
    logic [2:0]          idx;      // Write index in sequence
    logic [2:0]          len;      // Writes in sequence
    logic [CNT_W-1:0]    cnt;      // Phase timer
    logic                abort;    // Abort wait pending
    logic                blk_sel;  // Block select window open
    logic                done;
    logic                ce_b;
    logic                we_b;
    logic                oe_b;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq;
    logic                dq_oe;
    logic                busy;     // Writing or abort wait
  } fec_st_t;

  fec_st_t st;       // Registered state
  fec_st_t next_st;  // Next state

  // Sequencer: setup, strobe low, strobe high hold, per write
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.phase)
      FEC_IDLE: begin
        if (st.abort) begin
          // Reads are not valid while the device aborts the timeout
          if (st.cnt == CNT_W'(T_ABORT_CYC)) begin
            next_st.abort = 1'b0;
            next_st.done  = 1'b1;
          end else begin
            next_st.cnt = st.cnt + CNT_W'(1);
          end
        end else if (req_i) begin
          // Resets during block select trigger the abort wait
          next_st.abort   = st.blk_sel && (cmd_i == C_RESET || cmd_i == C_RESET3);
          // Repeating the sixth write adds a block, else full six writes
          next_st.idx     = (cmd_i == C_BLOCK && st.blk_sel) ? 3'h5 : 3'h0;
          next_st.blk_sel = (cmd_i == C_BLOCK);
          next_st.cmd     = cmd_i;
          next_st.len     = cmd_len(cmd_i);
          next_st.phase   = FEC_SETUP;
          next_st.cnt     = '0;
          next_st.oe_b    = 1'b1;
          next_st.ce_b    = 1'b0;
          next_st.dq_oe   = 1'b1;
          // First address and data stand before the strobe can fall
          next_st.addr    = wr_addr(cmd_i, next_st.idx, blk_addr_i, seq_addr_i);
          next_st.dq      = seq_data_i[next_st.idx*DATA_W +: DATA_W];
        end
      end
      FEC_SETUP: begin
        // Address and data already stand; only the setup time runs here
        if (st.cnt == CNT_W'(T_SETUP_CYC - 1)) begin
          next_st.we_b  = 1'b0;
          next_st.cnt   = '0;
          next_st.phase = FEC_PULSE;
        end else begin
          next_st.cnt = st.cnt + CNT_W'(1);
        end
      end
      // Strobe low for the pulse time
      FEC_PULSE: begin
        if (st.cnt == CNT_W'(T_PULSE_CYC - 1)) begin
          next_st.we_b  = 1'b1;
          next_st.cnt   = '0;
          next_st.phase = FEC_HOLD;
        end else begin
          next_st.cnt = st.cnt + CNT_W'(1);
        end
      end
      // Strobe high for hold and recovery, then next write or end
      FEC_HOLD: begin
        if (st.cnt == CNT_W'(T_HOLD_CYC - 1)) begin
          next_st.cnt = '0;
          if (st.idx + 3'h1 == st.len) begin
            // Sequence complete; abort wait holds done back
            next_st.phase = FEC_IDLE;
            next_st.ce_b  = 1'b1;
            next_st.dq_oe = 1'b0;
            next_st.done  = !st.abort;
          end else begin
            next_st.idx   = st.idx + 3'h1;
            // Next address and data change only while the strobe is high
            next_st.addr  = wr_addr(st.cmd, next_st.idx, blk_addr_i, seq_addr_i);
            next_st.dq    = seq_data_i[next_st.idx*DATA_W +: DATA_W];
            next_st.phase = FEC_SETUP;
          end
        end else begin
          next_st.cnt = st.cnt + CNT_W'(1);
        end
      end
      default: next_st.phase = FEC_IDLE;
    endcase
    // Busy is registered so that the pin comes from a flip-flop
    next_st.busy = (next_st.phase != FEC_IDLE) || next_st.abort;
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '{phase: FEC_IDLE, cmd: 3'h0, idx: 3'h0, len: 3'h0, cnt: '0,
              abort: 1'b0, blk_sel: 1'b0, done: 1'b0, ce_b: 1'b1, we_b: 1'b1,
              oe_b: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0, busy: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign busy_o      = st.busy;
  assign done_o      = st.done;
  assign chip_en_b_o = st.ce_b;
  assign wr_en_b_o   = st.we_b;
  assign out_en_b_o  = st.oe_b;
  assign addr_o      = st.addr;
  assign dq_o        = st.dq;
  assign dq_oe_o     = st.dq_oe;

  // Output enable stays high whenever the write strobe is low
  a_oe_high_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !st.we_b |-> st.oe_b && !st.ce_b) else $error("oe low in write");
  // Write strobe pulse lasts exactly its cycle count
  a_we_pulse_len: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $fell(st.we_b) |-> !st.we_b [*1] ##1 st.we_b) else $error("bad pulse");
  // Address stable while strobe low
  a_addr_stable: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !st.we_b |-> $stable(st.addr)) else $error("addr moved");
  // Data stable while strobe low
  a_data_stable: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !st.we_b |-> $stable(st.dq)) else $error("data moved");
  // Address and data still stand in the cycle after the strobe rises
  a_data_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(st.we_b) |-> $stable(st.dq) && $stable(st.addr)) else $error("no hold");
  // Chip enable is already low a cycle before the write strobe falls
  a_ce_setup: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $fell(st.we_b) |-> !$past(st.ce_b)) else $error("no ce setup");
  // Six-write chip erase ends in done after six strobes
  a_erase_six: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (st.phase == FEC_IDLE && req_i && !st.abort && cmd_i == C_CHIP)
      |-> ##19 st.done) else $error("chip erase length");
  // Abort wait ends with done in the cycle that busy falls
  a_abort_wait: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $fell(busy_o) && $past(st.abort) |-> st.done) else $error("abort end");
  // One-write reset in the window: one write, then the full abort wait
  a_abort_len: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(st.abort) && st.len == N_RESET |-> ##104 st.done) else $error("abort length");
  // Three-write reset in the window: three writes, then the full abort wait
  a_abort_long: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(st.abort) && st.len == N_RESET3 |-> ##110 st.done) else $error("abort long");
  // No bus activity while the device aborts
  a_abort_quiet: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    st.abort && st.phase == FEC_IDLE |-> st.ce_b && st.we_b && !st.dq_oe) else $error("abort bus");
  // One-write reset completes after three strobe phases
  a_reset_one: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (st.phase == FEC_IDLE && req_i && !st.abort && cmd_i == C_RESET && !st.blk_sel)
      |-> ##4 st.done) else $error("reset length");
  // Data driven whenever chip enabled
  a_dq_drive: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !st.ce_b |-> st.dq_oe) else $error("dq undriven");
  // A request while busy leaves the running sequence alone
  a_req_refused: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    st.busy && req_i |=> $stable(st.cmd) && $stable(st.len)) else $error("busy request taken");
  // Done only ever marks a finished sequence
  a_done_idle: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    st.done |-> st.phase == FEC_IDLE && !st.busy) else $error("done while busy");
  // Any command other than block erase closes the select window
  a_blk_window: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (st.phase == FEC_IDLE && req_i && !st.abort && cmd_i != C_BLOCK)
      |=> !st.blk_sel) else $error("window left open");
  // Added block uses only the sixth write
  a_blk_add: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (st.phase == FEC_IDLE && req_i && !st.abort && cmd_i == C_BLOCK && st.blk_sel)
      |-> ##4 st.done) else $error("block add");
endmodule : fec_host
`default_nettype wire

// >>> dv/fec_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// Device stand-in: logs the first 64 command writes seen on the flash pins
module fec_flash_model (
  input wire logic                        chip_en_b, // Chip enable, low
  input wire logic                        wr_en_b,   // Write enable, low
  input wire logic                        out_en_b,  // Output enable, low
  input wire logic [fec_pkg::ADDR_W-1:0]  addr,      // Address pins
  input wire logic [fec_pkg::DATA_W-1:0]  dq,        // Data pins
  input wire logic                        dq_oe      // Host drives data
);
  logic [fec_pkg::ADDR_W-1:0] cap_addr [64]; // Logged addresses
  logic [fec_pkg::DATA_W-1:0] cap_data [64]; // Logged data
  logic [fec_pkg::ADDR_W-1:0] lat_addr;      // Address until data edge
  int                         n_wr = 0;      // Writes logged
  int                         n_bad = 0;     // Malformed writes
  // Address on whichever strobe falls last
  always @(negedge wr_en_b or negedge chip_en_b) begin
    if (!wr_en_b && !chip_en_b) lat_addr = addr;
  end
  // Data on whichever strobe rises first; each write is one unit
  always @(posedge wr_en_b or posedge chip_en_b) begin
    if ((chip_en_b ^ wr_en_b) && n_wr < 64) begin
      cap_addr[n_wr] = lat_addr;
      cap_data[n_wr] = dq;
      // Output enable low or data undriven spoils the write
      if (out_en_b !== 1'b1 || dq_oe !== 1'b1) n_bad++;
      n_wr++;
    end
  end
endmodule : fec_flash_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fec_pkg::*;
  logic                  clock_i = 1'b0;  // 10 MHz clock
  logic                  rst_b_i = 1'b0;  // Reset, low
  logic                  req_i = 1'b0;    // Request
  logic [2:0]            cmd_i = 3'h0;    // Command code
  logic [ADDR_W-1:0]     blk_addr_i = 22'h3F0000; // Block to erase
  logic [ADDR_W*6-1:0]   seq_addr_i;      // Table addresses
  logic [DATA_W*6-1:0]   seq_data_i;      // Table data
  logic                  busy_o;          // Busy
  logic                  done_o;          // Done pulse
  logic                  ce_b;            // Chip enable pin
  logic                  we_b;            // Write enable pin
  logic                  oe_b;            // Output enable pin
  logic [ADDR_W-1:0]     addr;            // Address pins
  logic [DATA_W-1:0]     dq;              // Data pins
  logic                  dq_oe;           // Data drive enable
  int                    fail_count = 0;  // Mismatches
  int                    num_checks = 0;  // Comparisons
  int                    cyc_total = 0;   // Watchdog count
  fec_host dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req_i), .cmd_i(cmd_i),
    .blk_addr_i(blk_addr_i), .seq_addr_i(seq_addr_i), .seq_data_i(seq_data_i),
    .busy_o(busy_o), .done_o(done_o), .chip_en_b_o(ce_b), .wr_en_b_o(we_b),
    .out_en_b_o(oe_b), .addr_o(addr), .dq_o(dq), .dq_oe_o(dq_oe));
  fec_flash_model flash_u (.chip_en_b(ce_b), .wr_en_b(we_b), .out_en_b(oe_b),
    .addr(addr), .dq(dq), .dq_oe(dq_oe));
  // Clock
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  // Watchdog: whole run is a few hundred cycles
  always @(posedge clock_i) begin
    cyc_total++;
    if (cyc_total == 3000) begin
      fail_count++;
      $display("MISMATCH at %0t: run hung", $time);
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // One command; poke adds a request while busy, which must be dropped
  task automatic run_cmd(input logic [2:0] c, input int n, input int lat, input bit poke);
    int base;
    int cyc;
    int s;
    base = flash_u.n_wr;
    cyc = 0;
    cmd_i = c;
    req_i = 1'b1;
    @(negedge clock_i);
    check({31'h0, busy_o}, 32'h1);
    req_i = poke;
    cmd_i = C_RESET;
    while (done_o !== 1'b1 && cyc < 300) begin
      @(negedge clock_i);
      req_i = 1'b0;
      cyc++;
    end
    check(32'(cyc >= lat && cyc <= lat + 1), 32'h1);
    @(negedge clock_i);
    check({31'h0, done_o}, 32'h0);
    check({31'h0, busy_o}, 32'h0);
    check({31'h0, ce_b}, 32'h1);
    check({31'h0, dq_oe}, 32'h0);
    check(32'(flash_u.n_wr - base), 32'(n));
    check(32'(flash_u.n_bad), 32'h0);
    for (int k = 0; k < n; k++) begin
      // A lone block write is the sixth write of the table
      s = (c == C_BLOCK && n == 1) ? 5 : k;
      check(32'(flash_u.cap_data[base+k]), 32'(seq_data_i[s*DATA_W +: DATA_W]));
      if (c == C_BLOCK && s == 5) check(32'(flash_u.cap_addr[base+k]), 32'(blk_addr_i));
      else check(32'(flash_u.cap_addr[base+k]), 32'(seq_addr_i[s*ADDR_W +: ADDR_W]));
    end
  endtask : run_cmd
  task automatic t_reset();
    run_cmd(C_RESET, 1, 3, 1'b0);
    run_cmd(C_RESET3, 3, 9, 1'b1);
    $display("Test reset forms done");
  endtask : t_reset
  task automatic t_modes();
    run_cmd(C_IDENT, 3, 9, 1'b0);
    run_cmd(C_SUSP, 1, 3, 1'b0);
    run_cmd(C_QUERY, 1, 3, 1'b0);
    run_cmd(C_RESET, 1, 3, 1'b0);
    run_cmd(C_RESET, 1, 3, 1'b0);
    $display("Test modes done");
  endtask : t_modes
  task automatic t_chip();
    run_cmd(C_CHIP, 6, 18, 1'b1);
    $display("Test chip erase done");
  endtask : t_chip
  task automatic t_block();
    run_cmd(C_BLOCK, 6, 18, 1'b0);
    run_cmd(C_BLOCK, 1, 3, 1'b0);
    run_cmd(C_RESET, 1, 104, 1'b0);
    run_cmd(C_BLOCK, 6, 18, 1'b0);
    run_cmd(C_RESET3, 3, 110, 1'b0);
    run_cmd(C_BLOCK, 6, 18, 1'b1);
    $display("Test block erase done");
  endtask : t_block
  task automatic t_suspend();
    run_cmd(C_SUSP, 1, 3, 1'b0);
    run_cmd(C_IDENT, 3, 9, 1'b0);
    run_cmd(C_RESET, 1, 3, 1'b0);
    run_cmd(C_RESUME, 1, 3, 1'b0);
    run_cmd(C_BLOCK, 6, 18, 1'b0);
    $display("Test suspend done");
  endtask : t_suspend
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    for (int k = 0; k < 6; k++) begin
      seq_addr_i[k*ADDR_W +: ADDR_W] = 22'h2AA0 + 22'(k);
      seq_data_i[k*DATA_W +: DATA_W] = 16'hA550 + 16'(k);
    end
    repeat (6) @(negedge clock_i);
    rst_b_i = 1'b1;
    @(negedge clock_i);
    t_reset();
    t_modes();
    t_chip();
    t_block();
    t_suspend();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
